// file: src/urx_pkg.sv
`default_nettype none

package urx_pkg;

  // Oversampling of the asynchronous receiver
  localparam logic [4:0] SAMPLES_PER_BIT = 5'h10;
  localparam logic [4:0] VOTE_FIRST      = 5'h08;
  localparam logic [4:0] VOTE_MID        = 5'h09;
  localparam logic [4:0] VOTE_LAST       = 5'h0a;

  // Character size codes
  localparam logic [2:0] CHAR9_CODE      = 3'h7;
  localparam logic [3:0] CHAR_BASE_BITS  = 4'h5;
  localparam logic [3:0] CHAR9_BITS      = 4'h9;
  localparam logic [3:0] BYTE_BITS       = 4'h8;

  // Receive buffer
  localparam int         RX_FIFO_DEPTH   = 2;
  localparam int         RX_ENTRY_W      = 12;

  // One buffered frame: data, ninth bit and its error flags
  typedef struct packed {
    logic       rx_ninth_bit;
    logic       frame_error_flag;
    logic       overrun_flag;
    logic       parity_error_flag;
    logic [7:0] data;
  } urx_entry_t;

  // Control bits held by the CPU side
  typedef struct packed {
    logic       rx_enable_bit;
    logic       rx_complete_irq_en;
    logic       global_irq_en;
    logic       parity_enable_bit;
    logic       parity_odd_select;
    logic [2:0] char_size_field;
  } urx_ctrl_t;

  // Status bits seen by the CPU side
  typedef struct packed {
    logic       rx_complete_flag;
    logic       frame_error_flag;
    logic       overrun_flag;
    logic       parity_error_flag;
    logic       rx_ninth_bit;
  } urx_status_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PAR   = 5'h08,
    RX_STOP  = 5'h10
  } urx_state_t;

endpackage : urx_pkg

`default_nettype wire

// file: src/urx_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module urx_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [CW-1:0]               count;
    logic [WIDTH-1:0]            dout;
  } urx_fifo_state_t;

  urx_fifo_state_t s_q;
  urx_fifo_state_t s_d;
  logic            push;
  logic            pop;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : next_ptr

  // Head word sits in a register so the flags next to it never glitch
  always_comb begin
    s_d       = s_q;
    in_ready  = (s_q.count < CW'(DEPTH));
    out_valid = (s_q.count != '0);
    push      = in_valid && in_ready;
    pop       = out_ready && out_valid;
    if (flush) begin
      s_d = '0;
    end else begin
      if (push) begin
        s_d.mem[s_q.wr_ptr] = in_data;
        s_d.wr_ptr          = next_ptr(s_q.wr_ptr);
      end
      if (pop) begin
        s_d.rd_ptr = next_ptr(s_q.rd_ptr);
      end
      if (push && !pop) begin
        s_d.count = s_q.count + CW'(1);
      end else if (pop && !push) begin
        s_d.count = s_q.count - CW'(1);
      end
      if (pop) begin
        if (s_q.count > CW'(1)) begin
          s_d.dout = s_q.mem[next_ptr(s_q.rd_ptr)];
        end else if (push) begin
          s_d.dout = in_data;
        end else begin
          // An emptied head reads zero, so old flags never show
          s_d.dout = '0;
        end
      end else if (s_q.count == '0 && push) begin
        s_d.dout = in_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign out_data = s_q.dout;
  assign level    = s_q.count;

endmodule : urx_fifo

`default_nettype wire

// file: src/urx_receiver.sv
`timescale 1ns/1ps
`default_nettype none

module urx_receiver (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Serial side
  input  wire logic                rx_pin,
  input  wire logic                sample_tick,
  input  wire logic                sync_mode,
  input  wire logic                sync_clock_pin,
  output logic                     rx_pin_override,
  // CPU side
  input  wire urx_pkg::urx_ctrl_t  ctrl,
  input  wire logic                rx_data_read,
  output logic [7:0]               rx_data_port,
  output urx_pkg::urx_status_t     status,
  output logic                     rx_irq
);

  typedef struct packed {
    urx_pkg::urx_state_t state;
    logic [4:0]          cnt;
    logic [3:0]          bit_idx;
    logic [1:0]          votes;
    urx_pkg::urx_entry_t shr;
    logic [3:0]          nbits;
    logic                par_on;
    logic                pending;
    logic                ovr;
    logic                xck_q;
  } urx_rx_state_t;

  localparam int LW = $clog2(urx_pkg::RX_FIFO_DEPTH + 1);

  urx_rx_state_t       s_q;
  urx_rx_state_t       s_d;
  urx_pkg::urx_entry_t push_data;
  urx_pkg::urx_entry_t head;
  logic                push_ready;
  logic                head_valid;
  logic [LW-1:0]       level;
  logic                xck_rise;
  logic                tick;
  logic [4:0]          n;
  logic                maj;
  logic                bitval;
  logic                decide;
  logic                bit_end;
  logic                start_seen;
  logic                push_fire;

  function automatic logic [3:0] frame_bits(input logic [2:0] code);
    if (code == urx_pkg::CHAR9_CODE) begin
      frame_bits = urx_pkg::CHAR9_BITS;
    end else begin
      frame_bits = urx_pkg::CHAR_BASE_BITS + {2'h0, code[1:0]};
    end
  endfunction : frame_bits

  function automatic logic vote3(input logic a, input logic b, input logic c);
    vote3 = (a & b) | (a & c) | (b & c);
  endfunction : vote3

  // Sync clock is sampled as a plain input; its rising edge marks each bit
  assign xck_rise = sync_mode && sync_clock_pin && !s_q.xck_q;
  assign tick     = sync_mode ? xck_rise : sample_tick;
  assign n        = (s_q.cnt == urx_pkg::SAMPLES_PER_BIT) ? 5'h01 : s_q.cnt + 5'h01;
  assign maj      = vote3(s_q.votes[1], s_q.votes[0], rx_pin);
  // Sync mode takes one sample per bit, so no vote is possible there
  assign bitval   = sync_mode ? rx_pin : maj;
  assign decide   = sync_mode ? xck_rise : (sample_tick && n == urx_pkg::VOTE_LAST);
  assign bit_end  = sync_mode ? xck_rise : (sample_tick && n == urx_pkg::SAMPLES_PER_BIT);

  always_comb begin
    s_d        = s_q;
    s_d.xck_q  = sync_clock_pin;
    push_data  = s_q.shr;
    push_data.overrun_flag = s_q.ovr;
    push_fire  = s_q.pending && push_ready;
    start_seen = 1'b0;

    if (tick && s_q.state != urx_pkg::RX_IDLE) begin
      s_d.cnt = n;
      if (n == urx_pkg::VOTE_FIRST || n == urx_pkg::VOTE_MID) begin
        s_d.votes = {s_q.votes[0], rx_pin};
      end
    end

    // A waiting frame drops into the buffer as soon as there is room
    if (push_fire) begin
      s_d.pending = 1'b0;
      s_d.ovr     = 1'b0;
    end

    case (s_q.state)
      urx_pkg::RX_IDLE: begin
        if (tick && !rx_pin) begin
          start_seen = 1'b1;
        end
      end
      urx_pkg::RX_START: begin
        if (decide && bitval) begin
          s_d.state = urx_pkg::RX_IDLE;
        end else if (bit_end) begin
          s_d.state = urx_pkg::RX_DATA;
        end
      end
      urx_pkg::RX_DATA: begin
        if (decide) begin
          if (s_q.bit_idx < urx_pkg::BYTE_BITS) begin
            s_d.shr.data[s_q.bit_idx[2:0]] = bitval;
          end else begin
            s_d.shr.rx_ninth_bit = bitval;
          end
          s_d.bit_idx = s_q.bit_idx + 4'h1;
        end
        if (bit_end && s_d.bit_idx == s_q.nbits) begin
          s_d.state = s_q.par_on ? urx_pkg::RX_PAR : urx_pkg::RX_STOP;
        end
      end
      urx_pkg::RX_PAR: begin
        if (decide) begin
          // Expected bit is the data parity, inverted for odd parity
          s_d.shr.parity_error_flag = bitval ^ (^s_q.shr.data) ^ s_q.shr.rx_ninth_bit
                                      ^ ctrl.parity_odd_select;
        end
        if (bit_end) begin
          s_d.state = urx_pkg::RX_STOP;
        end
      end
      urx_pkg::RX_STOP: begin
        // Done at the vote of the first stop bit; any later stop bit is idle line
        if (decide) begin
          s_d.shr.frame_error_flag = !bitval;
          s_d.pending              = 1'b1;
          s_d.state                = urx_pkg::RX_IDLE;
        end
      end
      default: begin
        s_d.state = urx_pkg::RX_IDLE;
      end
    endcase

    if (start_seen) begin
      // A frame still waiting with a full buffer is lost to the new one
      if (s_q.pending && !push_ready) begin
        s_d.ovr     = 1'b1;
        s_d.pending = 1'b0;
      end
      s_d.shr     = '0;
      s_d.bit_idx = 4'h0;
      s_d.votes   = 2'h0;
      s_d.cnt     = 5'h01;
      s_d.nbits   = frame_bits(ctrl.char_size_field);
      // Latched here, so a later change of the enable cannot touch this frame
      s_d.par_on  = ctrl.parity_enable_bit;
      s_d.state   = sync_mode ? urx_pkg::RX_DATA : urx_pkg::RX_START;
    end

    // Receiver off: drop everything at once, even mid frame
    if (!ctrl.rx_enable_bit) begin
      s_d       = '0;
      s_d.state = urx_pkg::RX_IDLE;
      s_d.xck_q = sync_clock_pin;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q       <= '0;
      s_q.state <= urx_pkg::RX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Two entries match the documented buffer; the FIFO default of 8 is deeper
  urx_fifo #(
    .WIDTH (urx_pkg::RX_ENTRY_W),
    .DEPTH (urx_pkg::RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (!ctrl.rx_enable_bit),
    .in_valid  (s_q.pending),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (head_valid),
    .out_ready (rx_data_read),
    .out_data  (head),
    .level     (level)
  );

  // Status bits come straight from the head register and the buffer count, so writes cannot touch them
  assign rx_data_port              = head.data;
  assign status.rx_complete_flag   = head_valid;
  assign status.frame_error_flag   = head.frame_error_flag;
  assign status.overrun_flag       = head.overrun_flag;
  assign status.parity_error_flag  = head.parity_error_flag;
  assign status.rx_ninth_bit       = head.rx_ninth_bit;
  // Only the complete flag reaches the request line
  assign rx_irq          = ctrl.rx_complete_irq_en && ctrl.global_irq_en
                           && head_valid;
  assign rx_pin_override = ctrl.rx_enable_bit;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_disable_flush: assert property (
    !ctrl.rx_enable_bit |=> !status.rx_complete_flag ##0 s_q.state == urx_pkg::RX_IDLE)
    else $error("buffer not flushed after disable");

  a_irq_only_flag: assert property (
    rx_irq |-> status.rx_complete_flag && ctrl.rx_complete_irq_en)
    else $error("interrupt without complete flag");

  a_irq_holds: assert property (
    (status.rx_complete_flag && !rx_data_read && ctrl.rx_enable_bit)
    |=> status.rx_complete_flag && (rx_irq == (ctrl.rx_complete_irq_en && ctrl.global_irq_en)))
    else $error("interrupt dropped while flag set");

  a_parity_off: assert property (
    (s_q.pending && !s_q.par_on) |-> !push_data.parity_error_flag)
    else $error("parity error without checking");

  a_upper_zero: assert property (
    s_q.pending |-> ((push_data.data >> s_q.nbits) == 8'h00
                     || s_q.nbits >= urx_pkg::BYTE_BITS))
    else $error("unused data bits not zero");

  a_start_reject: assert property (
    (s_q.state == urx_pkg::RX_START && !sync_mode && decide && maj
     && ctrl.rx_enable_bit) |=> s_q.state == urx_pkg::RX_IDLE)
    else $error("noisy start bit accepted");

  a_overrun_set: assert property (
    (start_seen && s_q.pending && !push_ready && ctrl.rx_enable_bit)
    |=> s_q.ovr && !s_q.pending)
    else $error("overrun not recorded");

  a_overrun_clear: assert property (
    (push_fire && ctrl.rx_enable_bit) |=> !s_q.ovr)
    else $error("overrun kept after transfer");

  a_frame_error: assert property (
    (s_q.state == urx_pkg::RX_STOP && decide && ctrl.rx_enable_bit)
    |=> s_q.pending && (s_q.shr.frame_error_flag == !$past(bitval)))
    else $error("frame error not from stop bit");

  a_read_advance: assert property (
    (rx_data_read && level == LW'(1) && !push_fire && ctrl.rx_enable_bit)
    |=> !status.rx_complete_flag)
    else $error("read did not advance buffer");

  a_stop_to_buffer: assert property (
    (s_q.state == urx_pkg::RX_STOP && decide && ctrl.rx_enable_bit && level == '0
     && !rx_data_read)
    ##1 ctrl.rx_enable_bit |=> status.rx_complete_flag)
    else $error("frame not moved to buffer");

  a_read_keep: assert property (
    (rx_data_read && level == LW'(urx_pkg::RX_FIFO_DEPTH) && ctrl.rx_enable_bit)
    |=> status.rx_complete_flag)
    else $error("flag lost with data left");

  a_flush_level: assert property (
    !ctrl.rx_enable_bit
    |=> level == '0 && !s_q.pending && !s_q.ovr)
    else $error("buffer holds data while disabled");

  a_parity_state: assert property (
    (s_q.state == urx_pkg::RX_PAR)
    |-> s_q.par_on)
    else $error("parity bit taken while unchecked");

  a_par_latched: assert property (
    (s_q.state != urx_pkg::RX_IDLE && ctrl.rx_enable_bit)
    |=> s_q.par_on == $past(s_q.par_on))
    else $error("parity enable changed mid frame");

  a_overrun_hold: assert property (
    (s_q.ovr && !push_fire && ctrl.rx_enable_bit)
    |=> s_q.ovr)
    else $error("overrun lost before transfer");

  a_buffer_bound: assert property (
    ctrl.rx_enable_bit
    |-> level <= LW'(urx_pkg::RX_FIFO_DEPTH))
    else $error("buffer above two entries");

  a_start_accept: assert property (
    (s_q.state == urx_pkg::RX_START && !sync_mode && decide && !maj && ctrl.rx_enable_bit)
    |=> s_q.state == urx_pkg::RX_START)
    else $error("valid start bit dropped");

  a_stop_single: assert property (
    (s_q.state == urx_pkg::RX_STOP && decide && ctrl.rx_enable_bit)
    |=> s_q.state == urx_pkg::RX_IDLE)
    else $error("receiver waited for second stop bit");

  a_data_shift: assert property (
    (s_q.state == urx_pkg::RX_DATA && decide && s_q.bit_idx < urx_pkg::BYTE_BITS && ctrl.rx_enable_bit)
    |=> s_q.shr.data[$past(s_q.bit_idx[2:0])] == $past(bitval))
    else $error("data bit not shifted in");

  a_bit_count: assert property (
    (s_q.state == urx_pkg::RX_DATA && decide && ctrl.rx_enable_bit)
    |=> s_q.bit_idx == $past(s_q.bit_idx) + 4'h1)
    else $error("bit counter did not advance");

  a_ninth_zero: assert property (
    (s_q.pending && s_q.nbits != urx_pkg::CHAR9_BITS)
    |-> !push_data.rx_ninth_bit)
    else $error("ninth bit set in short frame");

  a_empty_head: assert property (
    !status.rx_complete_flag
    |-> status == '0 && rx_data_port == 8'h00)
    else $error("stale entry shown while empty");

endmodule : urx_receiver

`default_nettype wire

// file: test/urx_tx_model.sv
`timescale 1ns/1ps
`default_nettype none

module urx_tx_model (
  // Clock and baud ticks
  input  wire logic clk,
  input  wire logic sample_tick,
  // Serial line, idles high like a pulled-up wire
  output logic      line,
  // Synchronous bit clock, low between frames
  output logic      sync_clock_pin
);
  initial line = 1'b1;
  initial sync_clock_pin = 1'b0;

  // Holds a level for cnt ticks; entered and left at a falling edge
  task automatic hold_bit(input logic v, input int cnt);
    int n;
    n = 0;
    line = v;
    while (n < cnt) begin
      @(posedge clk);
      if (sample_tick) n++;
    end
    @(negedge clk);
  endtask : hold_bit

  // Start, data LSB first, optional parity (bad flips it), one stop bit
  task automatic send(input logic [8:0] d, input int nbits, input logic par, input logic odd,
                      input logic bad, input logic stop);
    logic p;
    p = odd ^ bad;
    hold_bit(1'b0, 16);
    for (int i = 0; i < nbits; i++) begin
      hold_bit(d[i], 16);
      p = p ^ d[i];
    end
    if (par) hold_bit(p, 16);
    // A single stop bit also shows the receiver needs no second one
    hold_bit(stop, 16);
    line = 1'b1;
  endtask : send

  // Synchronous frame: start, data LSB first, one stop; one rising clock edge per bit
  task automatic send_sync(input logic [8:0] d, input int nbits);
    for (int i = 0; i <= nbits + 1; i++) begin
      line = (i == 0) ? 1'b0 : (i > nbits) ? 1'b1 : d[i-1];
      @(negedge clk);
      sync_clock_pin = 1'b1;
      @(negedge clk);
      sync_clock_pin = 1'b0;
    end
    line = 1'b1;
  endtask : send_sync
endmodule : urx_tx_model

`default_nettype wire

// file: test/tb_urx_receiver.sv
`timescale 1ns/1ps
`default_nettype none

module tb_urx_receiver;
  logic                 clk;
  logic                 rst_n;
  logic                 rx_pin;
  logic                 sample_tick;
  logic                 sync_mode;
  logic                 sync_clock_pin;
  logic                 rx_pin_override;
  urx_pkg::urx_ctrl_t   ctrl;
  logic                 rx_data_read;
  logic [7:0]           rx_data_port;
  urx_pkg::urx_status_t status;
  logic                 rx_irq;
  int                   err_total;
  int                   check_count;
  int                   cycles;
  int                   nb;

  urx_tx_model far_end (.clk(clk), .sample_tick(sample_tick), .line(rx_pin), .sync_clock_pin(sync_clock_pin));

  urx_receiver DUT (.clk(clk), .rst_n(rst_n), .rx_pin(rx_pin), .sample_tick(sample_tick),
    .sync_mode(sync_mode), .sync_clock_pin(sync_clock_pin), .rx_pin_override(rx_pin_override), .ctrl(ctrl),
    .rx_data_read(rx_data_read), .rx_data_port(rx_data_port), .status(status), .rx_irq(rx_irq));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Tick every second cycle, so one bit lasts 32 clocks
  initial sample_tick = 1'b0;
  always @(negedge clk) sample_tick <= ~sample_tick;

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  // About 22 frames of up to 352 clocks each fit well below this ceiling
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      $display("[FAIL] %0t run hung", $time);
      give_verdict();
    end
  end

  task automatic chk_status(input urx_pkg::urx_status_t exp, input string what);
    check_count++;
    if (status !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s status %b expected %b", $time, what, status, exp);
    end
  endtask : chk_status

  task automatic chk_data(input logic [7:0] exp, input string what);
    check_count++;
    if (rx_data_port !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s data %h expected %h", $time, what, rx_data_port, exp);
    end
  endtask : chk_data

  task automatic chk_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s is %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit

  // One read pulse; the new head is settled a cycle later
  task automatic pop;
    rx_data_read = 1'b1;
    @(negedge clk);
    rx_data_read = 1'b0;
    @(negedge clk);
  endtask : pop

  // Flags are looked at before the data read that discards them
  task automatic expect_head(input logic [7:0] d, input urx_pkg::urx_status_t s);
    chk_status(s, "head flags");
    chk_data(d, "head data");
    pop();
  endtask : expect_head

  initial begin
    rst_n = 1'b0;
    ctrl = '0; // No status write path exists, so flag bits are never written
    sync_mode = 1'b0;
    rx_data_read = 1'b0;
    err_total = 0;
    check_count = 0;
    cycles = 0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk_status('0, "after reset");
    chk_bit(rx_pin_override, 1'b0, "pin while off");
    ctrl.rx_enable_bit = 1'b1;
    ctrl.rx_complete_irq_en = 1'b1;
    ctrl.global_irq_en = 1'b1;
    ctrl.char_size_field = 3'h3;
    @(negedge clk);
    chk_bit(rx_pin_override, 1'b1, "pin while on");
    far_end.hold_bit(1'b0, 8);
    far_end.hold_bit(1'b1, 200);
    chk_status('0, "noise start");
    far_end.send(9'h0a5, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    chk_bit(rx_irq, 1'b1, "irq pending");
    ctrl.global_irq_en = 1'b0;
    @(negedge clk);
    chk_bit(rx_irq, 1'b0, "irq global off");
    ctrl.global_irq_en = 1'b1;
    expect_head(8'ha5, 5'h10);
    chk_status('0, "drained");
    chk_bit(rx_irq, 1'b0, "irq empty");
    $display("test basic done");
    for (int c = 0; c < 5; c++) begin
      nb = (c == 4) ? 9 : c + 5;
      ctrl.char_size_field = (c == 4) ? urx_pkg::CHAR9_CODE : 3'(c);
      @(negedge clk);
      far_end.send(9'h1b6, nb, 1'b0, 1'b0, 1'b0, 1'b1);
      expect_head(8'(9'h1b6 & ((9'h1 << nb) - 9'h1)), {4'h8, c == 4});
    end
    $display("test sizes done");
    ctrl.char_size_field = 3'h3;
    ctrl.parity_enable_bit = 1'b1;
    for (int k = 0; k < 4; k++) begin
      ctrl.parity_odd_select = k[0];
      @(negedge clk);
      far_end.send(9'h0c3, 8, 1'b1, k[0], k[1], 1'b1);
      ctrl.parity_enable_bit = (k != 3);
      @(negedge clk);
      expect_head(8'hc3, {3'h4, k[1], 1'b0});
    end
    $display("test parity done");
    ctrl.rx_complete_irq_en = 1'b0;
    @(negedge clk);
    far_end.send(9'h05a, 8, 1'b0, 1'b0, 1'b0, 1'b0);
    chk_bit(rx_irq, 1'b0, "error irq");
    expect_head(8'h5a, 5'h18);
    far_end.send(9'h05b, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    expect_head(8'h5b, 5'h10);
    $display("test frame error done");
    ctrl.rx_complete_irq_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      far_end.send(9'(8'h10 + i), 8, 1'b0, 1'b0, 1'b0, 1'b1);
    end
    expect_head(8'h10, 5'h10);
    expect_head(8'h11, 5'h10);
    expect_head(8'h13, 5'h14);
    chk_status('0, "drain loop");
    far_end.send(9'h020, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    expect_head(8'h20, 5'h10);
    $display("test overrun done");
    far_end.send(9'h031, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    far_end.send(9'h032, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    ctrl.rx_enable_bit = 1'b0;
    repeat (2) @(negedge clk);
    chk_status('0, "flushed");
    chk_bit(rx_irq, 1'b0, "irq flushed");
    chk_bit(rx_pin_override, 1'b0, "pin released");
    ctrl.rx_enable_bit = 1'b1;
    fork
      far_end.send(9'h0e7, 8, 1'b0, 1'b0, 1'b0, 1'b1);
      begin
        repeat (100) @(negedge clk);
        ctrl.rx_enable_bit = 1'b0;
      end
    join
    ctrl.rx_enable_bit = 1'b1;
    repeat (2) @(negedge clk);
    chk_status('0, "aborted frame");
    far_end.send(9'h03c, 8, 1'b0, 1'b0, 1'b0, 1'b1);
    expect_head(8'h3c, 5'h10);
    $display("test disable done");
    sync_mode = 1'b1;
    ctrl.char_size_field = urx_pkg::CHAR9_CODE;
    @(negedge clk);
    far_end.send_sync(9'h14b, 9);
    repeat (2) @(negedge clk);
    expect_head(8'h4b, 5'h11);
    sync_mode = 1'b0;
    $display("test sync done");
    give_verdict();
  end
endmodule : tb_urx_receiver

`default_nettype wire
